// ===== bench/tb_vsc_top.sv
/*
 * self-checking bench for the set-point conditioning block.
 * assumes the source model stands in for storage and the analog inputs.
 */
`timescale 1ns/10ps
module tb_vsc_top;
    import vsc_pkg::*;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic nv_valid, wr = 1'b0, rd = 1'b0;
    logic closed_loop, cascade, error_led, ready;
    vsc_mode_t nv_mode, mode_sel = VSC_OPEN_AB;
    vsc_cmd_t nv_cmd, cmd_sel = VSC_CMD_4_20MA;
    vsc_ext_t nv_ext;
    logic [15:0] cmd_raw, ext_raw, set_point, ext_fb, coil_a, coil_b;
    logic [15:0] cmd_level = 16'h4000;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0000_0000, rdata, d;
    int err_count = 0, n_compared = 0;

    always #2.5 clock = ~clock;

    vsc_source_model i_vsc_source_model (.clock_i(clock), .reset_n_i(reset_n),
        .mode_sel_i(mode_sel), .cmd_sel_i(cmd_sel), .cmd_level_i(cmd_level),
        .nv_valid_o(nv_valid), .nv_mode_o(nv_mode), .nv_cmd_o(nv_cmd),
        .nv_ext_o(nv_ext), .cmd_raw_o(cmd_raw), .ext_raw_o(ext_raw));
    vsc_top i_vsc_top (.clock_i(clock), .reset_n_i(reset_n), .nv_valid_i(nv_valid),
        .nv_mode_i(nv_mode), .nv_cmd_i(nv_cmd), .nv_ext_i(nv_ext),
        .cmd_raw_i(cmd_raw), .ext_raw_i(ext_raw), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .set_point_o(set_point),
        .ext_fb_o(ext_fb), .coil_a_o(coil_a), .coil_b_o(coil_b),
        .closed_loop_o(closed_loop), .cascade_o(cascade), .error_led_o(error_led),
        .ready_o(ready));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic reg_wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clock);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask

    task automatic reg_rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1;
        v = rdata;
    endtask

    task automatic wait_sig(ref logic s, input logic v);
        for (int i = 0; i < 50 && s !== v; i++) begin
            @(posedge clock);
            #1;
        end
        chk({31'h0000_0000, s}, {31'h0000_0000, v});
    endtask

    // power cycle with a stored configuration
    task automatic power_up(input vsc_mode_t m);
        @(posedge clock);
        reset_n <= 1'b0;
        mode_sel <= m;
        repeat (3) @(posedge clock);
        reset_n <= 1'b1;
    endtask

    task automatic t_load_defaults;
        power_up(VSC_OPEN_AB);
        reg_wr(4'h1, 32'h0000_0020);
        #1;
        chk({16'h0000, coil_a}, 32'h0000_0000);
        wait_sig(ready, 1'b1);
        reg_rd(4'h1, d);
        chk(d, 32'h0000_0000);
        for (int a = 2; a <= 5; a++) begin
            reg_rd(a[3:0], d);
            chk(d, 32'h0000_2710);
        end
        reg_rd(4'h8, d);
        chk(d, 32'h0000_0100);
        reg_rd(4'hD, d);
        chk(d, 32'h0000_0000);
        reg_wr(4'h2, 32'h0000_0064);
        for (int a = 2; a <= 5; a++) begin
            reg_rd(a[3:0], d);
            chk(d, (a == 2) ? 32'h0000_0064 : 32'h0000_2710);
        end
        $display("test load_defaults done");
    endtask

    task automatic t_modes;
        for (int m = 0; m < 6; m++) begin
            power_up(vsc_mode_t'(m));
            wait_sig(ready, 1'b1);
            chk({31'h0000_0000, closed_loop}, (m >= 3));
            chk({31'h0000_0000, cascade}, (m == 5));
            reg_rd(4'hA, d);
            chk({29'h0000_0000, d[6:4]}, m);
            chk({30'h0000_0000, d[9:8]}, 32'h0000_0000);
        end
        power_up(VSC_OPEN_AB);
        wait_sig(ready, 1'b1);
        $display("test modes done");
    endtask

    task automatic t_staged;
        reg_wr(4'h0, 32'h0000_0345);
        reg_rd(4'h0, d);
        chk(d & 32'h0000_0377, 32'h0000_0345);
        reg_rd(4'hA, d);
        chk(d & 32'h0000_0370, 32'h0000_0000);
        chk({31'h0000_0000, closed_loop}, 32'h0000_0000);
        $display("test staged done");
    endtask

    task automatic t_loss;
        @(posedge clock);
        cmd_level <= 16'h1000;
        wait_sig(error_led, 1'b1);
        reg_rd(4'hA, d);
        chk({31'h0000_0000, d[0]}, 32'h0000_0001);
        @(posedge clock);
        cmd_level <= 16'h4000;
        wait_sig(error_led, 1'b0);
        reg_wr(4'h0, 32'h0000_0010);
        @(posedge clock);
        cmd_level <= 16'h1000;
        repeat (20) @(posedge clock);
        #1;
        chk({31'h0000_0000, error_led}, 32'h0000_0000);
        $display("test loss done");
    endtask

    // open-loop path: scaling, dead band, side split, min current, rise limit
    task automatic t_path;
        @(posedge clock);
        cmd_level <= 16'h4000;
        reg_wr(4'h6, 32'h0000_0100);
        repeat (8) @(posedge clock);
        #1;
        chk({16'h0000, set_point}, 32'h0000_4000);
        chk({16'h0000, coil_a}, 32'h0000_4100);
        chk({16'h0000, coil_b}, 32'h0000_0000);
        chk({16'h0000, ext_fb}, 32'h0000_4000);
        reg_rd(4'hB, d);
        chk(d, 32'h0000_4100);
        // 30 % band swallows a 25 % command
        reg_wr(4'h1, 32'h0000_001E);
        @(posedge clock);
        cmd_level <= 16'h2000;
        repeat (8) @(posedge clock);
        #1;
        chk({16'h0000, set_point}, 32'h0000_0000);
        chk({16'h0000, coil_a}, 32'h0000_0000);
        // bipolar command, negative half drives side B
        reg_wr(4'h1, 32'h0000_0000);
        reg_wr(4'h0, 32'h0000_0000);
        @(posedge clock);
        cmd_level <= 16'hC000;
        repeat (8) @(posedge clock);
        #1;
        chk({16'h0000, set_point}, 32'h0000_C000);
        chk({16'h0000, coil_b}, 32'h0000_4000);
        chk({16'h0000, coil_a}, 32'h0000_0000);
        // limited rise holds the step until the next sampling tick
        reg_wr(4'h2, 32'h0000_0064);
        @(posedge clock);
        cmd_level <= 16'h4000;
        repeat (8) @(posedge clock);
        #1;
        chk({16'h0000, set_point}, 32'h0000_0000);
        chk({16'h0000, coil_b}, 32'h0000_0000);
        $display("test path done");
    endtask

    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial begin
        #(20000 * 5);
        err_count++;
        wrap_up();
    end

    initial begin
        t_load_defaults();
        t_modes();
        t_staged();
        t_loss();
        t_path();
        wrap_up();
    end
endmodule

// ===== bench/vsc_source_model.sv
/*
 * far side: nonvolatile setting store and analog command/feedback source.
 * assumes reset_n_i stands for a supply power cycle.
 */
`timescale 1ns/10ps
module vsc_source_model
    import vsc_pkg::*;
#(
    parameter int LOAD_CYC = 8
) (
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire vsc_pkg::vsc_mode_t mode_sel_i,
    input wire vsc_pkg::vsc_cmd_t cmd_sel_i,
    input wire logic [15:0] cmd_level_i,
    output logic nv_valid_o,
    output vsc_pkg::vsc_mode_t nv_mode_o,
    output vsc_pkg::vsc_cmd_t nv_cmd_o,
    output vsc_pkg::vsc_ext_t nv_ext_o,
    output logic [15:0] cmd_raw_o,
    output logic [15:0] ext_raw_o
);
    int load_cnt;

    // stored settings only latched at power-up
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            load_cnt <= 0;
            nv_valid_o <= 1'b0;
            nv_mode_o <= mode_sel_i;
            nv_cmd_o <= cmd_sel_i;
            nv_ext_o <= VSC_EXT_0_10V;
            cmd_raw_o <= 16'h0000;
            ext_raw_o <= 16'h0000;
        end else begin
            if (load_cnt < LOAD_CYC) begin
                load_cnt <= load_cnt + 1;
            end
            nv_valid_o <= (load_cnt >= LOAD_CYC);
            cmd_raw_o <= cmd_level_i;
            ext_raw_o <= 16'h4000;
        end
    end
endmodule

// ===== bench/vsc_top_monitor.sv
/*
 * checker for the set-point conditioning block, watching top ports only.
 * assumes one clock domain and the bind at the foot of this file.
 */
`timescale 1ns/10ps
module vsc_top_monitor (
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic nv_valid_i,
    input wire logic [15:0] cmd_raw_i,
    input wire logic [3:0] addr_i,
    input wire logic rd_i,
    input wire logic [31:0] rdata_o,
    input wire logic [15:0] set_point_o,
    input wire logic [15:0] coil_a_o,
    input wire logic [15:0] coil_b_o,
    input wire logic closed_loop_o,
    input wire logic cascade_o,
    input wire logic error_led_o,
    input wire logic ready_o
);
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!reset_n_i);

    sequence good_cmd;
        ready_o && !cmd_raw_i[15] && (cmd_raw_i >= 16'h1666);
    endsequence
    sequence rate_read;
        rd_i && (addr_i >= 4'h2) && (addr_i <= 4'h5);
    endsequence

    a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0000_0000)
        else $error("read data not zero outside answer cycle");
    a_rate_width: assert property (rate_read |=> rdata_o[31:14] == 18'h0_0000)
        else $error("ramp rate wider than 14 bits");
    a_quiet_load: assert property (!ready_o |-> coil_a_o == 16'h0000 &&
        coil_b_o == 16'h0000 && set_point_o == 16'h0000)
        else $error("outputs driven before settings loaded");
    a_ready_src: assert property ($rose(ready_o) |-> $past(nv_valid_i, 2))
        else $error("ready without stored settings");
    a_ready_hold: assert property (ready_o |=> ready_o)
        else $error("ready dropped without reset");
    a_closed_coils: assert property (closed_loop_o |-> coil_a_o == 16'h0000 &&
        coil_b_o == 16'h0000)
        else $error("open-loop coil current in closed loop");
    a_cascade_closed: assert property (cascade_o |-> closed_loop_o)
        else $error("cascade without closed loop");
    a_mode_fixed: assert property (ready_o && $past(ready_o) |->
        $stable(closed_loop_o) && $stable(cascade_o))
        else $error("configuration changed while running");
    a_led_cause: assert property (good_cmd [*6] |-> !error_led_o)
        else $error("loss flag with healthy command");
    a_one_side: assert property (!(coil_a_o != 16'h0000 && coil_b_o != 16'h0000))
        else $error("both solenoids driven at once");
endmodule

bind vsc_top vsc_top_monitor i_vsc_top_monitor (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .nv_valid_i(nv_valid_i),
    .cmd_raw_i(cmd_raw_i),
    .addr_i(addr_i),
    .rd_i(rd_i),
    .rdata_o(rdata_o),
    .set_point_o(set_point_o),
    .coil_a_o(coil_a_o),
    .coil_b_o(coil_b_o),
    .closed_loop_o(closed_loop_o),
    .cascade_o(cascade_o),
    .error_led_o(error_led_o),
    .ready_o(ready_o)
);

// ===== rtl/vsc_defines.svh
/*
 * constants for the valve set-point conditioning block.
 * assumes a 200 MHz clock and signed 16-bit normalised samples.
 */
`ifndef VSC_DEFINES_SVH
`define VSC_DEFINES_SVH

`define VSC_CLK_HZ 200_000_000
// sampling tick period in microseconds and its cycle count
`define VSC_TICK_US 1000
`define VSC_TICK_CYC ((`VSC_CLK_HZ / 1_000_000) * `VSC_TICK_US)
// full scale of one polarity in normalised units
`define VSC_FS 16'sh7FFF
// ramp rate in percent per second; top value disables limiting
`define VSC_RATE_MAX 14'h2710
// per-tick step for 1 %/s scaled by 2^16, full scale 32767, 1 ms tick
`define VSC_STEP_PER_PCT 32'h0000_5400
// 4-20 mA: 3.5 mA loss threshold in raw signed units (20 mA = 7FFF)
`define VSC_LOS_RAW 16'sh1666
// 4 mA offset and 2 V offset in raw units
`define VSC_OFS_4MA 16'sh1999
`define VSC_OFS_2V 16'sh1999
// register offsets
`define VSC_REG_CFG 4'h0
`define VSC_REG_THR 4'h1
`define VSC_REG_RISE_A 4'h2
`define VSC_REG_FALL_A 4'h3
`define VSC_REG_RISE_B 4'h4
`define VSC_REG_FALL_B 4'h5
`define VSC_REG_MIN_A 4'h6
`define VSC_REG_MIN_B 4'h7
`define VSC_REG_GAIN_A 4'h8
`define VSC_REG_GAIN_B 4'h9
`define VSC_REG_STAT 4'hA
`define VSC_REG_OUT_A 4'hB
`define VSC_REG_OUT_B 4'hC
// cfg field layout
`define VSC_CFG_MODE_LSB 0
`define VSC_CFG_CMD_LSB 4
`define VSC_CFG_EXT_LSB 8
// reset defaults
`define VSC_THR_RST 8'h00
`define VSC_GAIN_RST 16'h0100

`endif

// ===== rtl/vsc_pkg.sv
/*
 * types for the valve set-point conditioning block.
 * assumes vsc_defines.svh for numeric constants.
 */
package vsc_pkg;
    typedef enum logic [2:0] {
        VSC_OPEN_AB, VSC_OPEN_A, VSC_OPEN_B, VSC_CLOSED_POS, VSC_CLOSED_EXT, VSC_CASCADE
    } vsc_mode_t;
    typedef enum logic [2:0] {
        VSC_CMD_BIP_V, VSC_CMD_UNI_V, VSC_CMD_BIP_MA, VSC_CMD_0_20MA, VSC_CMD_4_20MA
    } vsc_cmd_t;
    typedef enum logic [1:0] {
        VSC_EXT_0_10V, VSC_EXT_2_10V, VSC_EXT_0_20MA, VSC_EXT_4_20MA
    } vsc_ext_t;
    typedef enum logic [1:0] {
        VSC_ST_LOAD, VSC_ST_RUN
    } vsc_state_t;
endpackage

// ===== rtl/vsc_ramp.sv
/*
 * rate limiter for one solenoid side: steps toward target once per tick.
 * assumes tick is a one-cycle enable and rates are in percent per second.
 */
`timescale 1ns/10ps
`include "vsc_defines.svh"
module vsc_ramp (
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic tick_i,
    input wire logic [15:0] target_i,
    input wire logic [13:0] rise_i,
    input wire logic [13:0] fall_i,
    output logic [15:0] level_o
);
    logic [31:0] acc_r;
    logic [31:0] acc_nxt;
    logic [31:0] tgt;
    logic [31:0] step;

    function automatic logic [31:0] rate_step(input logic [13:0] rate);
        rate_step = 32'(rate) * `VSC_STEP_PER_PCT;
    endfunction

    always_comb begin
        tgt = {target_i, 16'h0000};
        acc_nxt = acc_r;
        step = 32'h0000_0000;
        if (tgt > acc_r) begin
            step = rate_step(rise_i);
            // max setting bypasses limiting
            if (rise_i >= `VSC_RATE_MAX) begin
                acc_nxt = tgt;
            end else if (tick_i) begin
                // last step clamps at target, never between ticks
                acc_nxt = (tgt - acc_r <= step) ? tgt : acc_r + step;
            end
        end else if (tgt < acc_r) begin
            step = rate_step(fall_i);
            if (fall_i >= `VSC_RATE_MAX) begin
                acc_nxt = tgt;
            end else if (tick_i) begin
                acc_nxt = (acc_r - tgt <= step) ? tgt : acc_r - step;
            end
        end
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            acc_r <= 32'h0000_0000;
        end else begin
            acc_r <= acc_nxt;
        end
    end

    assign level_o = acc_r[31:16];
endmodule

// ===== rtl/vsc_top.sv
/*
 * set-point conditioning: input scaling, loss detect, dead band, ramps,
 * open-loop coil current set points and register port.
 * assumes command and feedback arrive as asynchronous signed 16-bit samples
 * from an adc, and nonvolatile settings are presented on nv_* at reset.
 */
// Operation
// - open loop supports two-solenoid, side-A only and side-B only valves
// - open loop drives coil current roughly proportional to set point
// - closed loop on spool position, external feedback, or cascade
// - command type: bipolar V, 0-10 V, bipolar mA, 0-20 mA, 4-20 mA
// - bipolar on two solenoids: negative to side B, positive to side A
// - 4-20 mA below 3.5 mA flags error, lights led, centres valve
// - external feedback type selectable, default 0-10 V
// - new feedback type takes effect only after power cycle
// - dead band is percent of one-polarity full scale, no reaction below
// - dead band acts in every configuration
// - four independent ramp rates, rise and fall per side
// - ramps turn steps into constant-rate changes, open and closed loop
// - ramp slope independent of input type or range
// - 10000 %/s means no limiting and is the reset default
// - ramp output changes at constant rate until it reaches target
// - configuration change valid only after power cycle; command type here applies at once
// - open-loop coil current is min plus gain times command above threshold
`timescale 1ns/10ps
`include "vsc_defines.svh"
module vsc_top
    import vsc_pkg::*;
(
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic nv_valid_i,
    input wire vsc_pkg::vsc_mode_t nv_mode_i,
    input wire vsc_pkg::vsc_cmd_t nv_cmd_i,
    input wire vsc_pkg::vsc_ext_t nv_ext_i,
    input wire logic [15:0] cmd_raw_i,
    input wire logic [15:0] ext_raw_i,
    input wire logic [3:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    output logic [15:0] set_point_o,
    output logic [15:0] ext_fb_o,
    output logic [15:0] coil_a_o,
    output logic [15:0] coil_b_o,
    output logic closed_loop_o,
    output logic cascade_o,
    output logic error_led_o,
    output logic ready_o
);
    import vsc_pkg::*;

    // input synchronisers
    logic [15:0] cmd_s1_r, cmd_s2_r, ext_s1_r, ext_s2_r;
    logic nv_s1_r, nv_s2_r;
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cmd_s1_r <= 16'h0000;
            cmd_s2_r <= 16'h0000;
            ext_s1_r <= 16'h0000;
            ext_s2_r <= 16'h0000;
            nv_s1_r <= 1'b0;
            nv_s2_r <= 1'b0;
        end else begin
            cmd_s1_r <= cmd_raw_i;
            cmd_s2_r <= cmd_s1_r;
            ext_s1_r <= ext_raw_i;
            ext_s2_r <= ext_s1_r;
            nv_s1_r <= nv_valid_i;
            nv_s2_r <= nv_s1_r;
        end
    end

    // settings
    vsc_state_t state_r, state_nxt;
    vsc_mode_t mode_r, mode_nxt, mode_pend_r, mode_pend_nxt;
    vsc_cmd_t cmd_r, cmd_nxt;
    vsc_ext_t ext_r, ext_nxt, ext_pend_r, ext_pend_nxt;
    logic [7:0] thr_r, thr_nxt;
    logic [13:0] rate_r [4];
    logic [13:0] rate_nxt [4];
    logic [15:0] min_a_r, min_a_nxt, min_b_r, min_b_nxt;
    logic [15:0] gain_a_r, gain_a_nxt, gain_b_r, gain_b_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic err_r, err_nxt;

    function automatic logic [3:0] reg_sel(input logic [3:0] a);
        reg_sel = a;
    endfunction

    always_comb begin
        state_nxt = state_r;
        mode_nxt = mode_r;
        mode_pend_nxt = mode_pend_r;
        cmd_nxt = cmd_r;
        ext_nxt = ext_r;
        ext_pend_nxt = ext_pend_r;
        thr_nxt = thr_r;
        rate_nxt = rate_r;
        min_a_nxt = min_a_r;
        min_b_nxt = min_b_r;
        gain_a_nxt = gain_a_r;
        gain_b_nxt = gain_b_r;
        rdata_nxt = 32'h0000_0000;
        case (state_r)
            VSC_ST_LOAD: begin
                if (nv_s2_r) begin
                    // power-up load from nonvolatile store
                    mode_nxt = nv_mode_i;
                    mode_pend_nxt = nv_mode_i;
                    cmd_nxt = nv_cmd_i;
                    ext_nxt = nv_ext_i;
                    ext_pend_nxt = nv_ext_i;
                    state_nxt = VSC_ST_RUN;
                end
            end
            VSC_ST_RUN: begin
                if (wr_i) begin
                    case (reg_sel(addr_i))
                        `VSC_REG_CFG: begin
                            // mode and feedback type only staged until power cycle
                            mode_pend_nxt = vsc_mode_t'(wdata_i[`VSC_CFG_MODE_LSB +: 3]);
                            cmd_nxt = vsc_cmd_t'(wdata_i[`VSC_CFG_CMD_LSB +: 3]);
                            ext_pend_nxt = vsc_ext_t'(wdata_i[`VSC_CFG_EXT_LSB +: 2]);
                        end
                        `VSC_REG_THR: thr_nxt = wdata_i[7:0];
                        `VSC_REG_RISE_A: rate_nxt[0] = wdata_i[13:0];
                        `VSC_REG_FALL_A: rate_nxt[1] = wdata_i[13:0];
                        `VSC_REG_RISE_B: rate_nxt[2] = wdata_i[13:0];
                        `VSC_REG_FALL_B: rate_nxt[3] = wdata_i[13:0];
                        `VSC_REG_MIN_A: min_a_nxt = wdata_i[15:0];
                        `VSC_REG_MIN_B: min_b_nxt = wdata_i[15:0];
                        `VSC_REG_GAIN_A: gain_a_nxt = wdata_i[15:0];
                        `VSC_REG_GAIN_B: gain_b_nxt = wdata_i[15:0];
                        default: begin
                        end
                    endcase
                end
            end
            default: state_nxt = VSC_ST_LOAD;
        endcase
        if (rd_i) begin
            case (reg_sel(addr_i))
                `VSC_REG_CFG: rdata_nxt = {22'h0, ext_pend_r, 1'b0, cmd_r, 1'b0, mode_pend_r};
                `VSC_REG_THR: rdata_nxt = {24'h0, thr_r};
                `VSC_REG_RISE_A: rdata_nxt = {18'h0, rate_r[0]};
                `VSC_REG_FALL_A: rdata_nxt = {18'h0, rate_r[1]};
                `VSC_REG_RISE_B: rdata_nxt = {18'h0, rate_r[2]};
                `VSC_REG_FALL_B: rdata_nxt = {18'h0, rate_r[3]};
                `VSC_REG_MIN_A: rdata_nxt = {16'h0, min_a_r};
                `VSC_REG_MIN_B: rdata_nxt = {16'h0, min_b_r};
                `VSC_REG_GAIN_A: rdata_nxt = {16'h0, gain_a_r};
                `VSC_REG_GAIN_B: rdata_nxt = {16'h0, gain_b_r};
                `VSC_REG_STAT: rdata_nxt = {22'h0, ext_r, 1'b0, mode_r, 2'h0, state_r == VSC_ST_RUN,
                    err_r};
                `VSC_REG_OUT_A: rdata_nxt = {16'h0, coil_a_o};
                `VSC_REG_OUT_B: rdata_nxt = {16'h0, coil_b_o};
                default: rdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_r <= VSC_ST_LOAD;
            mode_r <= VSC_OPEN_AB;
            mode_pend_r <= VSC_OPEN_AB;
            cmd_r <= VSC_CMD_BIP_V;
            ext_r <= VSC_EXT_0_10V;
            ext_pend_r <= VSC_EXT_0_10V;
            thr_r <= `VSC_THR_RST;
            for (int i = 0; i < 4; i++) begin
                rate_r[i] <= `VSC_RATE_MAX;
            end
            min_a_r <= 16'h0000;
            min_b_r <= 16'h0000;
            gain_a_r <= `VSC_GAIN_RST;
            gain_b_r <= `VSC_GAIN_RST;
            rdata_r <= 32'h0000_0000;
        end else begin
            state_r <= state_nxt;
            mode_r <= mode_nxt;
            mode_pend_r <= mode_pend_nxt;
            cmd_r <= cmd_nxt;
            ext_r <= ext_nxt;
            ext_pend_r <= ext_pend_nxt;
            thr_r <= thr_nxt;
            rate_r <= rate_nxt;
            min_a_r <= min_a_nxt;
            min_b_r <= min_b_nxt;
            gain_a_r <= gain_a_nxt;
            gain_b_r <= gain_b_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // sampling tick divider
    logic [17:0] tick_cnt_r, tick_cnt_nxt;
    logic tick;
    always_comb begin
        tick = (tick_cnt_r == 18'(`VSC_TICK_CYC - 1));
        tick_cnt_nxt = tick ? 18'h0_0000 : tick_cnt_r + 18'h0_0001;
    end
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tick_cnt_r <= 18'h0_0000;
        end else begin
            tick_cnt_r <= tick_cnt_nxt;
        end
    end

    // scaling to a signed set point, full scale 7FFF one polarity
    logic signed [15:0] raw, sp, thr_abs;
    logic signed [31:0] thr_prod;
    logic [15:0] tgt_a, tgt_b, ramp_a, ramp_b, mag;
    logic los;
    always_comb begin
        raw = signed'(cmd_s2_r);
        los = 1'b0;
        case (cmd_r)
            VSC_CMD_BIP_V, VSC_CMD_BIP_MA: sp = raw;
            VSC_CMD_UNI_V, VSC_CMD_0_20MA: sp = (raw < 0) ? 16'sh0000 : raw;
            VSC_CMD_4_20MA: begin
                los = raw < `VSC_LOS_RAW;
                sp = (raw < `VSC_OFS_4MA) ? 16'sh0000 :
                    16'(((32'(raw) - 32'(`VSC_OFS_4MA)) * 32'sd5) >>> 2);
            end
            default: sp = 16'sh0000;
        endcase
        if (los) begin
            sp = 16'sh0000;
        end
        thr_prod = 32'(`VSC_FS) * 32'(thr_r) / 32'sd100;
        thr_abs = 16'(thr_prod);
        // dead band in every mode
        if (sp < thr_abs && sp > -thr_abs) begin
            sp = 16'sh0000;
        end
        mag = (sp < 0) ? 16'(-sp) : 16'(sp);
        tgt_a = 16'h0000;
        tgt_b = 16'h0000;
        case (mode_r)
            VSC_OPEN_A: tgt_a = mag;
            VSC_OPEN_B: tgt_b = mag;
            default: begin
                if (sp > 0) begin
                    tgt_a = mag;
                end else begin
                    tgt_b = mag;
                end
            end
        endcase
    end

    vsc_ramp u_ramp_a (
        .clock_i(clock_i),
        .reset_n_i(reset_n_i),
        .tick_i(tick),
        .target_i(tgt_a),
        .rise_i(rate_r[0]),
        .fall_i(rate_r[1]),
        .level_o(ramp_a)
    );
    vsc_ramp u_ramp_b (
        .clock_i(clock_i),
        .reset_n_i(reset_n_i),
        .tick_i(tick),
        .target_i(tgt_b),
        .rise_i(rate_r[2]),
        .fall_i(rate_r[3]),
        .level_o(ramp_b)
    );

    function automatic logic [15:0] coil(input logic [15:0] lvl, input logic [15:0] mn,
                                         input logic [15:0] g);
        logic [31:0] c;
        c = 32'(mn) + ((32'(lvl) * 32'(g)) >> 8);
        coil = (lvl == 16'h0000) ? 16'h0000 : (c > 32'h0000_FFFF) ? 16'hFFFF : c[15:0];
    endfunction

    // output stage
    logic [15:0] coil_a_r, coil_b_r, sp_r, ext_fb_r;
    logic cl_r, cas_r, rdy_r;
    logic signed [15:0] ext_v;
    logic signed [15:0] sp_out;
    always_comb begin
        err_nxt = los && state_r == VSC_ST_RUN;
        ext_v = signed'(ext_s2_r);
        case (ext_r)
            VSC_EXT_2_10V, VSC_EXT_4_20MA:
                ext_v = (ext_v < `VSC_OFS_2V) ? 16'sh0000 :
                    16'(((32'(ext_v) - 32'(`VSC_OFS_2V)) * 32'sd5) >>> 2);
            default: ext_v = (ext_v < 0) ? 16'sh0000 : ext_v;
        endcase
        sp_out = signed'(ramp_a) - signed'(ramp_b);
    end
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            coil_a_r <= 16'h0000;
            coil_b_r <= 16'h0000;
            sp_r <= 16'h0000;
            ext_fb_r <= 16'h0000;
            cl_r <= 1'b0;
            cas_r <= 1'b0;
            rdy_r <= 1'b0;
            err_r <= 1'b0;
        end else begin
            rdy_r <= state_r == VSC_ST_RUN;
            err_r <= err_nxt;
            sp_r <= (state_r == VSC_ST_RUN) ? sp_out : 16'h0000;
            ext_fb_r <= ext_v;
            cl_r <= mode_r == VSC_CLOSED_POS || mode_r == VSC_CLOSED_EXT
                || mode_r == VSC_CASCADE;
            cas_r <= mode_r == VSC_CASCADE;
            if (state_r == VSC_ST_RUN && mode_r <= VSC_OPEN_B) begin
                coil_a_r <= coil(ramp_a, min_a_r, gain_a_r);
                coil_b_r <= coil(ramp_b, min_b_r, gain_b_r);
            end else begin
                coil_a_r <= 16'h0000;
                coil_b_r <= 16'h0000;
            end
        end
    end

    assign rdata_o = rdata_r;
    assign set_point_o = sp_r;
    assign ext_fb_o = ext_fb_r;
    assign coil_a_o = coil_a_r;
    assign coil_b_o = coil_b_r;
    assign closed_loop_o = cl_r;
    assign cascade_o = cas_r;
    assign error_led_o = err_r;
    assign ready_o = rdy_r;
endmodule
